// >>> core/uhspb_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the host
 scheduler and packet memory block. Assumes a 125 MHz register clock.
*/
`ifndef UHSPB_DEFS_SVH
`define UHSPB_DEFS_SVH
`define UHSPB_CTRL        12'h000
`define UHSPB_STAT        12'h004
`define UHSPB_CHOUT       12'h008
`define UHSPB_CHIN        12'h00C
`define UHSPB_CHPER       12'h010
`define UHSPB_DADDR       12'h014
`define UHSPB_BTABLE      12'h018
`define UHSPB_FRAME       12'h01C
`define UHSPB_MEM_BIT     11
`define UHSPB_HOST_BIT    0
`define UHSPB_FRST_BIT    1
`define UHSPB_PWR_BIT     2
`define UHSPB_EF_BIT      7
`define UHSPB_BRST_BIT    0
`define UHSPB_OVR_BIT     3
`define UHSPB_CTRL_RST    32'h0000_0002
`define UHSPB_CLK_NS      8
`define UHSPB_FRAME_NS    1000000
`define UHSPB_SECURE_NS   40000
`define UHSPB_FRAME_CYC   (`UHSPB_FRAME_NS / `UHSPB_CLK_NS)
`define UHSPB_SECURE_CYC  ((`UHSPB_SECURE_NS + `UHSPB_CLK_NS - 1) / `UHSPB_CLK_NS)
`endif

// >>> core/uhspb_pkg.sv
/*
 Types of the host scheduler and packet memory block.
 Assumes uhspb_defs.svh for all numeric constants.
*/
package uhspb_pkg;
	typedef enum logic [1:0] {
		ST_WAIT = 2'b00,
		ST_PER  = 2'b01,
		ST_NPER = 2'b10,
		ST_SEC  = 2'b11
	} uhspb_win_type;
endpackage : uhspb_pkg

// >>> core/uhspb_pktmem.sv
/*
 Packet memory of 512 words with a time-duplex arbiter for the register
 side and the USB engine. Assumes requests hold until granted.
*/
`timescale 1ns/100ps
module uhspb_pktmem
	import uhspb_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        cpu_req,
	input  wire logic        cpu_we,
	input  wire logic [8:0]  cpu_addr,
	input  wire logic [31:0] cpu_wdata,
	input  wire logic [3:0]  cpu_be,
	output logic             cpu_gnt,
	output logic             cpu_rvalid,
	input  wire logic        usb_req,
	input  wire logic        usb_we,
	input  wire logic [8:0]  usb_addr,
	input  wire logic [31:0] usb_wdata,
	output logic             usb_gnt,
	output logic             usb_rvalid,
	output logic [31:0]      rdata
);
	logic [31:0] mem [0:511];
	logic        phase;
	logic        next_phase;
	logic        next_cpu_rvalid;
	logic        next_usb_rvalid;

	// Phase 0 belongs to the processor, phase 1 to USB; an idle owner lends it
	always_comb begin
		cpu_gnt = cpu_req && (!phase || !usb_req);
		usb_gnt = usb_req && !cpu_gnt;
		next_phase = !phase;
		next_cpu_rvalid = cpu_gnt && !cpu_we;
		next_usb_rvalid = usb_gnt && !usb_we;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase <= 1'b0;
			cpu_rvalid <= 1'b0;
			usb_rvalid <= 1'b0;
		end else begin
			phase <= next_phase;
			cpu_rvalid <= next_cpu_rvalid;
			usb_rvalid <= next_usb_rvalid;
		end
	end

	// No reset on the array: contents are software-owned
	always_ff @(posedge aclk) begin
		if (cpu_gnt) begin
			for (int b = 0; b < 4; b++) begin
				if (cpu_we && cpu_be[b]) begin
					mem[cpu_addr][8*b +: 8] <= cpu_wdata[8*b +: 8];
				end
			end
			rdata <= mem[cpu_addr];
		end else if (usb_gnt) begin
			if (usb_we) begin
				mem[usb_addr] <= usb_wdata;
			end
			rdata <= mem[usb_addr];
		end
	end

	sequence s_usb_waits;
		usb_req && !usb_gnt;
	endsequence

	property p_usb_half;
		@(posedge aclk) disable iff (!aresetn) s_usb_waits |=> usb_gnt || !usb_req;
	endproperty
	a_usb_half: assert property (p_usb_half) else $error("usb starved");

	property p_cpu_first;
		@(posedge aclk) disable iff (!aresetn) cpu_req && !phase |-> cpu_gnt && !usb_gnt;
	endproperty
	a_cpu_first: assert property (p_cpu_first) else $error("cpu not favoured");

	property p_rd_lat;
		@(posedge aclk) disable iff (!aresetn) cpu_gnt && !cpu_we |=> cpu_rvalid && !usb_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data late");
endmodule : uhspb_pktmem

// >>> core/uhspb_top.sv
/*
 Host frame scheduler, bus-reset handling and packet memory access
 behind an AXI4-Lite slave. Assumes one 125 MHz clock, a transaction
 engine that pulses txn_done, and a USB data stream that holds valid.
*/
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "uhspb_defs.svh"
module uhspb_top
	import uhspb_pkg::*;
#(
	parameter int FRAME_CYC    = `UHSPB_FRAME_CYC,
	parameter int SECURE_START = `UHSPB_FRAME_CYC - `UHSPB_SECURE_CYC
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             txn_req,
	output logic [2:0]       txn_ch,
	output logic             txn_dir,
	output logic             txn_periodic,
	output logic [8:0]       txn_desc_addr,
	input  wire logic        txn_done,
	output logic             sof_pulse,
	input  wire logic        bus_reset_in,
	output logic [31:0]      ctrl,
	output logic [7:0]       daddr,
	input  wire logic        usb_buf_start,
	input  wire logic [8:0]  usb_buf_base,
	input  wire logic [8:0]  usb_buf_words,
	input  wire logic        usb_acc_valid,
	input  wire logic        usb_acc_we,
	input  wire logic [31:0] usb_acc_wdata,
	output logic             usb_acc_ready,
	output logic             usb_rvalid,
	output logic [31:0]      mem_rdata,
	output logic             usb_overrun
);
	function automatic logic [15:0] slots(input logic [7:0] o, input logic [7:0] i);
		logic [15:0] r;
		r = 16'h0000;
		for (int k = 0; k < 8; k++) begin
			r[2*k] = o[k];
			r[2*k+1] = i[k];
		end
		return r;
	endfunction : slots

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) r[8*b +: 8] = n[8*b +: 8];
		end
		return r;
	endfunction : merge

	logic [11:0] waddr, raddr, next_waddr, next_raddr;
	logic [31:0] wdata, next_wdata, next_rdata;
	logic [3:0]  wstrb, next_wstrb;
	logic        aw_have, w_have, ar_have, rd_wait;
	logic        next_aw_have, next_w_have, next_ar_have, next_rd_wait;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic        wr_go, rd_go, reg_wr, reg_ok, cpu_req, cpu_we, cpu_gnt, cpu_rvalid;
	logic [31:0] rd_mux;
	logic [31:0] next_ctrl, stat, next_stat, btable, next_btable;
	logic [7:0]  chout, chin, chper, next_chout, next_chin, next_chper, next_daddr;
	uhspb_win_type win, next_win;
	logic [3:0]  slot, next_slot;
	logic [15:0] per_snap, next_per_snap, np_live;
	logic [16:0] frame, next_frame;
	logic        run, next_sof, next_req, next_dir, next_per;
	logic [2:0]  next_ch;
	logic [8:0]  usb_ptr, usb_words, next_usb_ptr, next_usb_words, usb_base, next_usb_base;
	logic        next_usb_over, usb_req, usb_gnt;

	assign wr_go = aw_have && w_have && !s_axi_bvalid;
	assign rd_go = ar_have && !s_axi_rvalid;
	assign reg_wr = wr_go && !waddr[`UHSPB_MEM_BIT];
	assign cpu_we = wr_go && waddr[`UHSPB_MEM_BIT];
	assign cpu_req = cpu_we || (rd_go && raddr[`UHSPB_MEM_BIT] && !rd_wait);
	assign s_axi_awready = !aw_have;
	assign s_axi_wready = !w_have;
	assign s_axi_arready = !ar_have;

	always_comb begin
		reg_ok = 1'b1;
		case (raddr)
			`UHSPB_CTRL:   rd_mux = ctrl;
			`UHSPB_STAT:   rd_mux = stat;
			`UHSPB_CHOUT:  rd_mux = {24'h000000, chout};
			`UHSPB_CHIN:   rd_mux = {24'h000000, chin};
			`UHSPB_CHPER:  rd_mux = {24'h000000, chper};
			`UHSPB_DADDR:  rd_mux = {24'h000000, daddr};
			`UHSPB_BTABLE: rd_mux = btable;
			`UHSPB_FRAME:  rd_mux = {15'h0000, frame};
			default: begin
				rd_mux = 32'h0000_0000;
				reg_ok = 1'b0;
			end
		endcase
	end

	// Bus slave: one write and one read in flight
	always_comb begin
		next_aw_have = aw_have;
		next_w_have = w_have;
		next_ar_have = ar_have;
		next_waddr = waddr;
		next_wdata = wdata;
		next_wstrb = wstrb;
		next_raddr = raddr;
		next_rd_wait = rd_wait;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		if (s_axi_awvalid && !aw_have) begin
			next_aw_have = 1'b1;
			next_waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have) begin
			next_w_have = 1'b1;
			next_wdata = s_axi_wdata;
			next_wstrb = s_axi_wstrb;
		end
		if (s_axi_arvalid && !ar_have) begin
			next_ar_have = 1'b1;
			next_raddr = s_axi_araddr;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
			next_aw_have = 1'b0;
			next_w_have = 1'b0;
		end else if (reg_wr || (cpu_we && cpu_gnt)) begin
			next_bvalid = 1'b1;
			next_bresp = (cpu_we || waddr <= `UHSPB_FRAME) ? 2'b00 : 2'b10;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_ar_have = 1'b0;
		end else if (rd_go && !raddr[`UHSPB_MEM_BIT]) begin
			next_rvalid = 1'b1;
			next_rdata = rd_mux;
			next_rresp = reg_ok ? 2'b00 : 2'b10;
		end else if (rd_wait && cpu_rvalid) begin
			next_rvalid = 1'b1;
			next_rdata = mem_rdata;
			next_rresp = 2'b00;
			next_rd_wait = 1'b0;
		end else if (cpu_gnt && !cpu_we) begin
			next_rd_wait = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			ar_have <= 1'b0;
			rd_wait <= 1'b0;
			waddr <= 12'h000;
			wdata <= 32'h0000_0000;
			wstrb <= 4'h0;
			raddr <= 12'h000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			ar_have <= next_ar_have;
			rd_wait <= next_rd_wait;
			waddr <= next_waddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			raddr <= next_raddr;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
		end
	end

	// Registers; a software write wins over hardware clears in the same cycle
	always_comb begin
		next_ctrl = ctrl;
		next_stat = stat;
		next_chout = chout;
		next_chin = chin;
		next_chper = chper;
		next_daddr = daddr;
		next_btable = btable;
		next_stat[2:1] = next_win;
		if (txn_req && txn_done) begin
			if (txn_dir) next_chin[txn_ch] = 1'b0;
			else next_chout[txn_ch] = 1'b0;
		end
		if (!ctrl[`UHSPB_HOST_BIT] && bus_reset_in) begin
			next_chout = 8'h00;
			next_chin = 8'h00;
			next_daddr = 8'h00;
		end
		if (reg_wr) begin
			case (waddr)
				`UHSPB_CTRL:   next_ctrl = merge(ctrl, wdata, wstrb);
				`UHSPB_STAT:   next_stat = next_stat & ~(wdata & 32'h0000_0009);
				`UHSPB_CHOUT:  next_chout = wstrb[0] ? wdata[7:0] : chout;
				`UHSPB_CHIN:   next_chin = wstrb[0] ? wdata[7:0] : chin;
				`UHSPB_CHPER:  next_chper = wstrb[0] ? wdata[7:0] : chper;
				`UHSPB_DADDR:  next_daddr = wstrb[0] ? wdata[7:0] : daddr;
				`UHSPB_BTABLE: next_btable = merge(btable, wdata, wstrb) & 32'h0000_07F8;
				default: next_ctrl = ctrl;
			endcase
		end
		// Hardware sets beat a same-cycle clear
		if (!ctrl[`UHSPB_HOST_BIT] && bus_reset_in) next_stat[`UHSPB_BRST_BIT] = 1'b1;
		if (usb_overrun) next_stat[`UHSPB_OVR_BIT] = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `UHSPB_CTRL_RST;
			stat <= 32'h0000_0000;
			chout <= 8'h00;
			chin <= 8'h00;
			chper <= 8'h00;
			daddr <= 8'h00;
			btable <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			stat <= next_stat;
			chout <= next_chout;
			chin <= next_chin;
			chper <= next_chper;
			daddr <= next_daddr;
			btable <= next_btable;
		end
	end

	// Frame scheduler; held in wait with the frame count cleared while forced reset holds the bus in reset
	assign run = ctrl[`UHSPB_HOST_BIT] && ctrl[`UHSPB_PWR_BIT] && !ctrl[`UHSPB_FRST_BIT];
	assign np_live = slots(chout & ~chper, chin & ~chper);
	always_comb begin
		next_win = win;
		next_slot = slot;
		next_per_snap = per_snap;
		next_frame = frame;
		next_sof = 1'b0;
		next_req = txn_req;
		next_ch = txn_ch;
		next_dir = txn_dir;
		next_per = txn_periodic;
		if (!run) begin
			next_win = ST_WAIT;
			next_frame = 17'h00000;
			next_req = 1'b0;
		end else begin
			next_frame = (frame == 17'(FRAME_CYC - 1)) ? 17'h00000 : frame + 17'h00001;
			if (txn_req && txn_done) next_req = 1'b0;
			case (win)
				ST_PER: begin
					if (!txn_req) begin
						if (per_snap[slot]) begin
							next_req = 1'b1;
							next_per = 1'b1;
							next_ch = slot[3:1];
							next_dir = slot[0];
						end
						next_per_snap[slot] = 1'b0;
						next_slot = slot + 4'h1;
						if (slot == 4'hF) next_win = ST_NPER;
					end
				end
				ST_NPER: begin
					if (!txn_req) begin
						if (np_live[slot]) begin
							next_req = 1'b1;
							next_per = 1'b0;
							next_ch = slot[3:1];
							next_dir = slot[0];
						end
						next_slot = slot + 4'h1;
					end
				end
				ST_WAIT, ST_SEC: next_slot = slot;
				default: next_win = ST_WAIT;
			endcase
			if (frame == 17'(SECURE_START)) next_win = ST_SEC;
			if (frame == 17'(FRAME_CYC - 1)) begin
				next_sof = 1'b1;
				next_win = ST_PER;
				next_slot = 4'h0;
				next_per_snap = slots(chout & chper, chin & chper);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			win <= ST_WAIT;
			slot <= 4'h0;
			per_snap <= 16'h0000;
			frame <= 17'h00000;
			sof_pulse <= 1'b0;
			txn_req <= 1'b0;
			txn_ch <= 3'h0;
			txn_dir <= 1'b0;
			txn_periodic <= 1'b0;
		end else begin
			win <= next_win;
			slot <= next_slot;
			per_snap <= next_per_snap;
			frame <= next_frame;
			sof_pulse <= next_sof;
			txn_req <= next_req;
			txn_ch <= next_ch;
			txn_dir <= next_dir;
			txn_periodic <= next_per;
		end
	end
	assign txn_desc_addr = 9'(btable[10:2] + {5'h00, txn_ch, txn_dir});

	// USB stream: bottom-up, excess words are swallowed without a write
	// Engine port runs on aclk; a separate 48 MHz engine needs its crossing outside
	assign usb_req = usb_acc_valid && !usb_overrun && usb_ptr != usb_words;
	assign usb_acc_ready = usb_gnt || (usb_acc_valid && usb_ptr == usb_words);
	always_comb begin
		next_usb_ptr = usb_ptr;
		next_usb_base = usb_base;
		next_usb_words = usb_words;
		next_usb_over = usb_overrun;
		if (usb_buf_start) begin
			next_usb_ptr = 9'h000;
			next_usb_base = usb_buf_base;
			next_usb_words = usb_buf_words;
			next_usb_over = 1'b0;
		end else if (usb_gnt) begin
			next_usb_ptr = usb_ptr + 9'h001;
		end else if (usb_acc_valid && usb_ptr == usb_words) begin
			next_usb_over = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			usb_ptr <= 9'h000;
			usb_base <= 9'h000;
			usb_words <= 9'h000;
			usb_overrun <= 1'b0;
		end else begin
			usb_ptr <= next_usb_ptr;
			usb_base <= next_usb_base;
			usb_words <= next_usb_words;
			usb_overrun <= next_usb_over;
		end
	end

	uhspb_pktmem i_uhspb_pktmem (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.cpu_req    (cpu_req),
		.cpu_we     (cpu_we),
		.cpu_addr   (cpu_we ? waddr[10:2] : raddr[10:2]),
		.cpu_wdata  (wdata),
		.cpu_be     (wstrb),
		.cpu_gnt    (cpu_gnt),
		.cpu_rvalid (cpu_rvalid),
		.usb_req    (usb_req),
		.usb_we     (usb_acc_we),
		.usb_addr   (9'(usb_base + usb_ptr)),
		.usb_wdata  (usb_acc_wdata),
		.usb_gnt    (usb_gnt),
		.usb_rvalid (usb_rvalid),
		.rdata      (mem_rdata)
	);

	sequence s_issue;
		!txn_req ##1 txn_req;
	endsequence
	property p_no_sec_issue;
		@(posedge aclk) disable iff (!aresetn) s_issue |-> $past(win) != ST_SEC && $past(run);
	endproperty
	a_no_sec_issue: assert property (p_no_sec_issue) else $error("issue in security window");
	property p_per_in_per;
		@(posedge aclk) disable iff (!aresetn) s_issue ##0 txn_periodic |-> $past(win) == ST_PER;
	endproperty
	a_per_in_per: assert property (p_per_in_per) else $error("periodic outside window");
	property p_np_class;
		@(posedge aclk) disable iff (!aresetn)
			s_issue ##0 !txn_periodic |-> !$past(chper[next_ch]) && $past(win) == ST_NPER;
	endproperty
	a_np_class: assert property (p_np_class) else $error("periodic served as best effort");
	property p_sof_start;
		@(posedge aclk) disable iff (!aresetn) sof_pulse |-> win == ST_PER && slot == 4'h0;
	endproperty
	a_sof_start: assert property (p_sof_start) else $error("frame start wrong");
	property p_per_pass;
		@(posedge aclk) disable iff (!aresetn)
			win == ST_PER && slot == 4'hF && !txn_req && run && frame != 17'(FRAME_CYC - 1)
			&& frame != 17'(SECURE_START) |=> win == ST_NPER;
	endproperty
	a_per_pass: assert property (p_per_pass) else $error("periodic pass not closed");
	property p_secure;
		@(posedge aclk) disable iff (!aresetn) run && frame == 17'(SECURE_START) ##1 run |-> win == ST_SEC;
	endproperty
	a_secure: assert property (p_secure) else $error("security window missed");
	property p_busrst;
		@(posedge aclk) disable iff (!aresetn)
			!ctrl[`UHSPB_HOST_BIT] && bus_reset_in && !reg_wr |=> chout == 8'h00 && chin == 8'h00;
	endproperty
	a_busrst: assert property (p_busrst) else $error("endpoints live after bus reset");
	property p_bound;
		@(posedge aclk) disable iff (!aresetn)
			usb_gnt && !usb_buf_start |-> usb_ptr < usb_words ##1 usb_ptr != 9'h000;
	endproperty
	a_bound: assert property (p_bound) else $error("write beyond buffer");
endmodule : uhspb_top

// >>> verification/uhspb_engine_model.sv
/*
 Transaction engine model: answers each scheduler request with a one-cycle
 done pulse, alternately prompt and slow, and logs {periodic, ch, dir}.
 Assumes txn_req falls the cycle after done is seen.
*/
`timescale 1ns/100ps
module uhspb_engine_model
	import uhspb_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       txn_req,
	input  wire logic [2:0] txn_ch,
	input  wire logic       txn_dir,
	input  wire logic       txn_periodic,
	output logic            txn_done
);
	logic [3:0] cnt;
	logic       slow;
	logic       seen;
	logic [4:0] log [$];

	// Seen flag stops a second pulse while req is still falling
	always_ff @(posedge aclk) begin
		txn_done <= 1'b0;
		if (!aresetn) begin
			cnt  <= 4'h0;
			slow <= 1'b0;
			seen <= 1'b0;
		end else if (txn_req && !seen) begin
			cnt <= cnt + 4'h1;
			if (cnt == (slow ? 4'h4 : 4'h0)) begin
				txn_done <= 1'b1;
				seen     <= 1'b1;
				slow     <= !slow;
				cnt      <= 4'h0;
				log.push_back({txn_periodic, txn_ch, txn_dir});
			end
		end else if (!txn_req) begin
			seen <= 1'b0;
		end
	end
endmodule : uhspb_engine_model

// >>> verification/test_uhspb.sv
/*
 Self-checking bench of the scheduler and packet memory block.
 Assumes a short frame of 200 cycles with the security window at 150.
*/
`timescale 1ns/100ps
`include "uhspb_defs.svh"
module test_uhspb;
	import uhspb_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0;
	logic rrdy = 1'b0, brst = 1'b0, ustart = 1'b0, uv = 1'b0, uwe = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0, uwd = 32'h0, mrd, rv;
	logic [1:0]  rr;
	logic        txn_req, txn_dir, txn_per, txn_done, sof, bv, rvl, aw_r, w_r, ar_r, uready, uovr;
	logic [2:0]  txn_ch;
	logic [8:0]  desc;
	logic [1:0]  br, rresp, wr_resp;
	logic        urv;
	logic [31:0] ctrl, rdata;
	logic [7:0]  daddr;
	int n_mismatch = 0, cmp_count = 0, n;

	always #4 aclk = ~aclk;

	uhspb_top #(.FRAME_CYC(200), .SECURE_START(150)) i_uhspb_top (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(w_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_r),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rrdy),
		.txn_req(txn_req), .txn_ch(txn_ch), .txn_dir(txn_dir), .txn_periodic(txn_per),
		.txn_desc_addr(desc), .txn_done(txn_done), .sof_pulse(sof), .bus_reset_in(brst),
		.ctrl(ctrl), .daddr(daddr), .usb_buf_start(ustart), .usb_buf_base(9'h010),
		.usb_buf_words(9'h002), .usb_acc_valid(uv), .usb_acc_we(uwe),
		.usb_acc_wdata(uwd), .usb_acc_ready(uready), .usb_rvalid(urv), .mem_rdata(mrd),
		.usb_overrun(uovr));

	uhspb_engine_model i_uhspb_engine_model (
		.aclk(aclk), .aresetn(aresetn), .txn_req(txn_req), .txn_ch(txn_ch),
		.txn_dir(txn_dir), .txn_periodic(txn_per), .txn_done(txn_done));

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic stuck(input logic ok);
		if (!ok) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : stuck

	// Ready is sampled at the falling edge, so the handshake edge never races
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		logic t, ha, hw;
		@(posedge aclk);
		awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1; t = 1'b0;
		for (int i = 0; i < 99 && !t; i++) begin
			@(negedge aclk);
			ha = awv & aw_r; hw = wv & w_r; t = bv; wr_resp = br;
			@(posedge aclk);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
		end
		brdy <= 1'b0;
		stuck(t);
	endtask : axw

	task automatic axr(input logic [11:0] a);
		logic t, h;
		@(posedge aclk);
		ara <= a; arv <= 1'b1; rrdy <= 1'b1; t = 1'b0;
		for (int i = 0; i < 99 && !t; i++) begin
			@(negedge aclk);
			h = arv & ar_r; t = rvl; rv = rdata; rr = rresp;
			@(posedge aclk);
			if (h) arv <= 1'b0;
		end
		rrdy <= 1'b0;
		stuck(t);
	endtask : axr

	task automatic upush(input logic w, input logic [31:0] d);
		logic g;
		@(posedge aclk);
		uv <= 1'b1; uwe <= w; uwd <= d; g = 1'b0;
		for (int i = 0; i < 20 && !g; i++) begin
			@(negedge aclk);
			g = uready;
			@(posedge aclk);
		end
		uv <= 1'b0;
		stuck(g);
	endtask : upush

	task automatic t_regs_mem;
		axr(`UHSPB_CTRL); chk(rv, `UHSPB_CTRL_RST);
		axr(12'h020); chk(32'(rr), 32'h2);
		axw(12'h020, 32'h0000_00FF); chk(32'(wr_resp), 32'h2);
		axw(`UHSPB_CHPER, 32'h0); chk(32'(wr_resp), 32'h0);
		axw(12'h800, 32'hA5A5_0001); axw(12'hFFC, 32'h1234_5678);
		axr(12'h800); chk(rv, 32'hA5A5_0001);
		axr(12'hFFC); chk(rv, 32'h1234_5678);
	endtask : t_regs_mem

	// Enable first: the first frame after enabling stays idle
	task automatic t_sched;
		axw(`UHSPB_STAT, 32'h9);
		axw(`UHSPB_BTABLE, 32'h104);
		axr(`UHSPB_BTABLE); chk(rv, 32'h100);
		// Power up under forced reset; no frame may start meanwhile
		axw(`UHSPB_CTRL, 32'h7);
		for (n = 0; n < 250 && sof !== 1'b1; n++) @(negedge aclk);
		chk(32'(sof), 32'h0);
		axw(`UHSPB_CTRL, 32'h5); chk(ctrl, 32'h5);
		axw(`UHSPB_CHOUT, 32'h5); axw(`UHSPB_CHIN, 32'h4); axw(`UHSPB_CHPER, 32'h4);
		for (n = 0; n < 900 && i_uhspb_engine_model.log.size() < 3; n++) @(posedge aclk);
		stuck(n < 900);
		chk(32'(i_uhspb_engine_model.log[0]), 32'h14);
		chk(32'(i_uhspb_engine_model.log[1]), 32'h15);
		chk(32'(i_uhspb_engine_model.log[2]), 32'h00);
		rv = 32'h0;
		for (n = 0; n < 300 && !(rv >= 160 && rv < 180); n++) axr(`UHSPB_FRAME);
		stuck(n < 300);
		axw(`UHSPB_CHOUT, 32'h2);
		for (n = 0; n < 300 && sof !== 1'b1; n++) @(negedge aclk);
		stuck(n < 300);
		chk(i_uhspb_engine_model.log.size(), 3);
		for (n = 0; n < 300 && i_uhspb_engine_model.log.size() < 4; n++) @(posedge aclk);
		stuck(n < 300);
		chk(32'(i_uhspb_engine_model.log[3]), 32'h02);
		chk(32'(desc), 32'h42);
	endtask : t_sched

	task automatic t_bus_reset;
		axw(`UHSPB_CTRL, 32'h4); axw(`UHSPB_DADDR, 32'h85); axw(`UHSPB_CHOUT, 32'h1);
		@(posedge aclk); brst <= 1'b1;
		repeat (2) @(posedge aclk);
		brst <= 1'b0;
		axr(`UHSPB_CHOUT); chk(rv, 32'h0);
		chk(32'(daddr), 32'h0);
		axr(`UHSPB_STAT); chk(rv, 32'h1);
		axw(`UHSPB_DADDR, 32'h80); chk(32'(daddr), 32'h80);
		axw(`UHSPB_CHOUT, 32'h1);
		axr(`UHSPB_CHOUT); chk(rv, 32'h1);
	endtask : t_bus_reset

	// Third word overruns a two-word buffer and must be dropped
	task automatic t_stream;
		axw(12'h848, 32'hDEAD_BEEF);
		@(posedge aclk); ustart <= 1'b1;
		@(posedge aclk); ustart <= 1'b0;
		upush(1'b1, 32'h1111_0000); upush(1'b1, 32'h2222_0000); upush(1'b1, 32'h3333_0000);
		@(negedge aclk); chk(32'(uovr), 32'h1);
		axr(12'h840); chk(rv, 32'h1111_0000);
		axr(12'h844); chk(rv, 32'h2222_0000);
		axr(12'h848); chk(rv, 32'hDEAD_BEEF);
		// Processor and stream hit the memory in the same cycle
		@(posedge aclk);
		ustart <= 1'b1;
		@(posedge aclk);
		ustart <= 1'b0;
		fork
			axw(12'h84C, 32'h4444_0000);
			begin
				@(posedge aclk);
				upush(1'b1, 32'h5555_0000);
			end
		join
		upush(1'b0, 32'h0000_0000);
		@(negedge aclk);
		chk(32'(urv), 32'h1);
		chk(mrd, 32'h2222_0000);
		chk(32'(uovr), 32'h0);
		axr(12'h840); chk(rv, 32'h5555_0000);
		axr(12'h84C); chk(rv, 32'h4444_0000);
	endtask : t_stream

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs_mem();
		t_sched();
		t_bus_reset();
		t_stream();
		wrap_up();
	end
endmodule : test_uhspb
